// *** design/adcc_pkg.sv ***
package adcc_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_SC1 = 8'h00;
   localparam logic [7:0] ADDR_SC2 = 8'h04;
   localparam logic [7:0] ADDR_RH = 8'h08;
   localparam logic [7:0] ADDR_RL = 8'h0C;
   localparam logic [7:0] ADDR_CVH = 8'h10;
   localparam logic [7:0] ADDR_CVL = 8'h14;
   localparam logic [7:0] ADDR_IST = 8'h18;
   localparam logic [7:0] ADDR_IMSK = 8'h1C;

   // Field positions, primary status/control
   localparam int DONE_BIT = 7;
   localparam int IEN_BIT = 6;
   localparam int CONT_BIT = 5;
   localparam int CH_MSB = 4;
   // Field positions, second control
   localparam int ACT_BIT = 7;
   localparam int TRIG_BIT = 6;
   localparam int CMPEN_BIT = 5;
   localparam int CMPGE_BIT = 4;
   // Event status bits
   localparam int IST_W = 3;
   localparam int IST_DONE = 0;
   localparam int IST_MISS = 1;
   localparam int IST_ABORT = 2;

   // Channel codes
   localparam int NUM_INPUTS = 28;
   localparam logic [4:0] CH_LAST_INPUT = 5'h1B;
   localparam logic [4:0] CH_RSVD = 5'h1C;
   localparam logic [4:0] CH_REFH = 5'h1D;
   localparam logic [4:0] CH_REFL = 5'h1E;
   localparam logic [4:0] CH_OFF = 5'h1F;

   // Reset values
   localparam logic [4:0] SC1_CH_RST = CH_OFF;
   localparam logic [IST_W-1:0] IMSK_RST = 3'h0;

   localparam int RES_W = 10;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // Converter timing
   localparam int SYS_CLK_NS = 20;
   localparam int ADCK_NS = 200;
   localparam int ADCK_DIV = (ADCK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam logic [7:0] DIV_LAST = 8'(ADCK_DIV - 1);
   localparam int SAMPLE_TICKS = 4;
   localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_TICKS - 1);
   localparam logic [3:0] MSB_IDX = 4'(RES_W - 1);
endpackage : adcc_pkg

// *** design/adcc_sar.sv ***
module adcc_sar (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic abort,
   input wire logic cmp_above,
   output logic [adcc_pkg::RES_W-1:0] dac_code,
   output logic busy,
   output logic done,
   output logic [adcc_pkg::RES_W-1:0] result
);
   typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_BITS} adcc_sar_st_t;

   typedef struct packed {
      adcc_sar_st_t st;
      logic [7:0] div;
      logic [3:0] tcnt;
      logic [3:0] bit_idx;
      logic [adcc_pkg::RES_W-1:0] code;
      logic busy;
      logic done;
      logic [adcc_pkg::RES_W-1:0] result;
   } adcc_sar_regs_t;

   adcc_sar_regs_t r_q;
   adcc_sar_regs_t r_d;
   logic tick;
   logic [adcc_pkg::RES_W-1:0] trial;

   function automatic logic [adcc_pkg::RES_W-1:0] bit_mask(
      input logic [3:0] idx);
      bit_mask = {{(adcc_pkg::RES_W-1){1'b0}}, 1'b1} << idx;
   endfunction : bit_mask

   always_comb begin
      r_d = r_q;
      r_d.done = 1'b0;
      tick = (r_q.div == adcc_pkg::DIV_LAST);
      trial = r_q.code;
      // Free-running divider gives the conversion clock enable
      r_d.div = tick ? 8'h00 : r_q.div + 8'h01;
      if (start) begin
         r_d.st = SAR_SAMPLE;
         r_d.tcnt = 4'h0;
         r_d.div = 8'h00;
         r_d.code = '0;
         r_d.busy = 1'b1;
      end else if (abort) begin
         r_d.st = SAR_IDLE;
         r_d.code = '0;
         r_d.busy = 1'b0;
      end else begin
         unique case (r_q.st)
            SAR_IDLE: begin
            end
            SAR_SAMPLE: begin
               if (tick) begin
                  if (r_q.tcnt == adcc_pkg::SAMPLE_LAST) begin
                     r_d.st = SAR_BITS;
                     r_d.bit_idx = adcc_pkg::MSB_IDX;
                     r_d.code = bit_mask(adcc_pkg::MSB_IDX);
                  end else begin
                     r_d.tcnt = r_q.tcnt + 4'h1;
                  end
               end
            end
            SAR_BITS: begin
               if (tick) begin
                  // Comparator low means the trial bit overshot
                  if (!cmp_above) begin
                     trial = r_q.code & ~bit_mask(r_q.bit_idx);
                  end
                  if (r_q.bit_idx == 4'h0) begin
                     r_d.result = trial;
                     r_d.done = 1'b1;
                     r_d.busy = 1'b0;
                     r_d.code = '0;
                     r_d.st = SAR_IDLE;
                  end else begin
                     r_d.code = trial | bit_mask(r_q.bit_idx - 4'h1);
                     r_d.bit_idx = r_q.bit_idx - 4'h1;
                  end
               end
            end
            default: begin
               r_d.st = SAR_IDLE;
            end
         endcase
      end
      if (reset) begin
         r_d = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      r_q <= r_d;
   end

   assign dac_code = r_q.code;
   assign busy = r_q.busy;
   assign done = r_q.done;
   assign result = r_q.result;
endmodule : adcc_sar

// *** design/adcc_top.sv ***
// Behaviour
// - SC1 write aborts, restarts unless channel off or hardware trigger selected
// - Done flag bit 7, set without compare
// - With compare, done only when compare true
// - Done cleared by SC1 write, low read
// - Interrupt while done set and enable high
// - One conversion per write or trigger
// - Continuous bit repeats after write or trigger
// - Channel select is SC1 bits 4:0
// - All-ones code powers off, isolates input
// - Off code ends continuous without extra conversion
// - Low power after single conversion completes
// - Twenty-eight selectable analog inputs
// - Codes 0-27 select inputs, 11100 reserved
// - 11101 high reference, 11110 low reference
// - Second control bit 6 selects trigger
// - Active bit 7 set start, cleared end
// - Compare less-than, or greater-equal when bit 4
// - Result updates unless compare enabled and false
module adcc_top (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic hw_trigger_input,
   input wire logic cmp_above,
   output logic [adcc_pkg::RES_W-1:0] dac_code,
   output logic converter_enable,
   output logic input_isolate,
   output logic [adcc_pkg::NUM_INPUTS-1:0] analog_input_sel,
   output logic ref_high_sel,
   output logic ref_low_sel,
   output logic irq
);
   typedef struct packed {
      logic ph_wr;
      logic ph_rd;
      logic [7:0] ph_addr;
      logic [31:0] hrdata;
      logic hready;
      logic hresp;
      logic done;
      logic ien;
      logic cont;
      logic [4:0] ch;
      logic act;
      logic trig;
      logic cmpen;
      logic cmpge;
      logic [adcc_pkg::RES_W-1:0] result;
      logic [adcc_pkg::RES_W-1:0] cv;
      logic [adcc_pkg::IST_W-1:0] ist;
      logic [adcc_pkg::IST_W-1:0] imsk;
      logic hwt_prev;
      logic restart;
      logic irq;
      logic pwr;
      logic iso;
      logic [adcc_pkg::NUM_INPUTS-1:0] ain_sel;
      logic refh;
      logic refl;
   } adcc_regs_t;

   adcc_regs_t r_q;
   adcc_regs_t r_d;
   logic start;
   logic abort;
   logic wr_sc1;
   logic hwt_rise;
   logic upd;
   logic eng_done;
   logic eng_busy;
   logic [adcc_pkg::RES_W-1:0] eng_result;

   function automatic logic cmp_hit(
      input logic [adcc_pkg::RES_W-1:0] res,
      input logic [adcc_pkg::RES_W-1:0] cv,
      input logic ge);
      cmp_hit = ge ? (res >= cv) : (res < cv);
   endfunction : cmp_hit

   function automatic logic [adcc_pkg::NUM_INPUTS-1:0] ch_decode(
      input logic [4:0] ch);
      ch_decode = '0;
      // reserved and reference codes pick no input
      if (ch <= adcc_pkg::CH_LAST_INPUT) begin
         ch_decode[ch] = 1'b1;
      end
   endfunction : ch_decode

   assign wr_sc1 = r_q.ph_wr && (r_q.ph_addr == adcc_pkg::ADDR_SC1);
   assign hwt_rise = hw_trigger_input && !r_q.hwt_prev;
   // update only on a met compare when enabled
   assign upd = !r_q.cmpen || cmp_hit(eng_result, r_q.cv, r_q.cmpge);

   always_comb begin
      r_d = r_q;
      start = 1'b0;
      abort = 1'b0;
      r_d.hwt_prev = hw_trigger_input;
      // continuous repeat one cycle after completion
      if (r_q.restart) begin
         r_d.restart = 1'b0;
         if (r_q.cont && r_q.ch != adcc_pkg::CH_OFF && !r_q.act) begin
            start = 1'b1;
         end
      end
      // hardware trigger edge starts when selected
      if (r_q.trig && hwt_rise && !r_q.act &&
          r_q.ch != adcc_pkg::CH_OFF) begin
         start = 1'b1;
      end
      if (r_q.ph_wr) begin
         case (r_q.ph_addr)
            adcc_pkg::ADDR_SC1: begin
               r_d.ien = hwdata[adcc_pkg::IEN_BIT];
               r_d.cont = hwdata[adcc_pkg::CONT_BIT];
               r_d.ch = hwdata[adcc_pkg::CH_MSB:0];
               r_d.done = 1'b0;
               // a pending repeat dies with the write
               r_d.restart = 1'b0;
               abort = r_q.act;
               // software start only in software mode
               start = (hwdata[adcc_pkg::CH_MSB:0] != adcc_pkg::CH_OFF)
                  && !r_q.trig;
            end
            adcc_pkg::ADDR_SC2: begin
               r_d.trig = hwdata[adcc_pkg::TRIG_BIT];
               r_d.cmpen = hwdata[adcc_pkg::CMPEN_BIT];
               r_d.cmpge = hwdata[adcc_pkg::CMPGE_BIT];
            end
            adcc_pkg::ADDR_CVH: begin
               r_d.cv[9:8] = hwdata[1:0];
            end
            adcc_pkg::ADDR_CVL: begin
               r_d.cv[7:0] = hwdata[7:0];
            end
            adcc_pkg::ADDR_IMSK: begin
               r_d.imsk = hwdata[adcc_pkg::IST_W-1:0];
            end
            default: begin
            end
         endcase
      end
      if (r_q.ph_rd) begin
         r_d.ph_rd = 1'b0;
         r_d.hready = 1'b1;
         case (r_q.ph_addr)
            adcc_pkg::ADDR_SC1: begin
               r_d.hrdata = {24'h000000, r_q.done, r_q.ien, r_q.cont,
                  r_q.ch};
            end
            adcc_pkg::ADDR_SC2: begin
               r_d.hrdata = {24'h000000, r_q.act, r_q.trig, r_q.cmpen,
                  r_q.cmpge, 4'h0};
            end
            adcc_pkg::ADDR_RH: begin
               r_d.hrdata = {30'h00000000, r_q.result[9:8]};
            end
            adcc_pkg::ADDR_RL: begin
               r_d.hrdata = {24'h000000, r_q.result[7:0]};
               r_d.done = 1'b0;
            end
            adcc_pkg::ADDR_CVH: begin
               r_d.hrdata = {30'h00000000, r_q.cv[9:8]};
            end
            adcc_pkg::ADDR_CVL: begin
               r_d.hrdata = {24'h000000, r_q.cv[7:0]};
            end
            adcc_pkg::ADDR_IST: begin
               r_d.hrdata = {29'h00000000, r_q.ist};
               r_d.ist = '0;
            end
            adcc_pkg::ADDR_IMSK: begin
               r_d.hrdata = {29'h00000000, r_q.imsk};
            end
            default: begin
               r_d.hrdata = 32'h00000000;
            end
         endcase
      end
      // Completion comes after the read clears so a set wins; an SC1 write drops it
      if (eng_done && !wr_sc1) begin
         if (upd) begin
            r_d.result = eng_result;
            r_d.done = 1'b1;
            r_d.ist[adcc_pkg::IST_DONE] = 1'b1;
         end else begin
            r_d.ist[adcc_pkg::IST_MISS] = 1'b1;
         end
         r_d.restart = r_q.cont;
      end
      // active cleared at completion or abort
      if (eng_done || abort) begin
         r_d.act = 1'b0;
      end
      if (abort) begin
         r_d.ist[adcc_pkg::IST_ABORT] = 1'b1;
      end
      if (start) begin
         r_d.act = 1'b1;
      end
      // Reads take one wait state so that hrdata comes from a flop
      r_d.ph_wr = 1'b0;
      if (hsel && htrans[1] && hready && hsize == adcc_pkg::HSIZE_WORD)
      begin
         r_d.ph_addr = haddr[7:0];
         r_d.ph_wr = hwrite;
         if (!hwrite) begin
            r_d.ph_rd = 1'b1;
            r_d.hready = 1'b0;
         end
      end
      r_d.pwr = r_d.act && r_d.ch != adcc_pkg::CH_OFF;
      r_d.iso = (r_d.ch == adcc_pkg::CH_OFF);
      r_d.ain_sel = ch_decode(r_d.ch);
      r_d.refh = (r_d.ch == adcc_pkg::CH_REFH);
      r_d.refl = (r_d.ch == adcc_pkg::CH_REFL);
      // level interrupt from done or masked events
      r_d.irq = (r_d.done && r_d.ien) || |(r_d.ist & r_d.imsk);
      if (reset) begin
         r_d = '0;
         r_d.ch = adcc_pkg::SC1_CH_RST;
         r_d.imsk = adcc_pkg::IMSK_RST;
         r_d.iso = 1'b1;
         r_d.hready = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      r_q <= r_d;
   end

   // Start has priority inside the engine, so abort may stay high
   adcc_sar u_sar (
      .sys_clk(sys_clk),
      .reset(reset),
      .start(start),
      .abort(abort),
      .cmp_above(cmp_above),
      .dac_code(dac_code),
      .busy(eng_busy),
      .done(eng_done),
      .result(eng_result)
   );

   assign hrdata = r_q.hrdata;
   assign hreadyout = r_q.hready;
   assign hresp = r_q.hresp;
   assign converter_enable = r_q.pwr;
   assign input_isolate = r_q.iso;
   assign analog_input_sel = r_q.ain_sel;
   assign ref_high_sel = r_q.refh;
   assign ref_low_sel = r_q.refl;
   assign irq = r_q.irq;

   AST_WR_START: assert property (
      @(posedge sys_clk) disable iff (reset)
      wr_sc1 && hwdata[4:0] != adcc_pkg::CH_OFF && !r_q.trig
      |=> r_q.act && !r_q.done ##1 eng_busy)
      else $error("write did not start a conversion");

   AST_OFF_STOPS: assert property (
      @(posedge sys_clk) disable iff (reset)
      wr_sc1 && hwdata[4:0] == adcc_pkg::CH_OFF
      |=> !r_q.act && !converter_enable && input_isolate
      && analog_input_sel == '0 ##1 !eng_busy)
      else $error("off code left the converter running");

   AST_DONE_NOCMP: assert property (
      @(posedge sys_clk) disable iff (reset)
      eng_done && !wr_sc1 && !r_q.cmpen |=> r_q.done)
      else $error("done flag missing after completion");

   AST_CMP_MISS: assert property (
      @(posedge sys_clk) disable iff (reset)
      eng_done && r_q.cmpen && !wr_sc1
      && !cmp_hit(eng_result, r_q.cv, r_q.cmpge)
      |=> $stable(r_q.result) && r_q.ist[adcc_pkg::IST_MISS])
      else $error("result changed on a failed compare");

   AST_RL_CLEAR: assert property (
      @(posedge sys_clk) disable iff (reset)
      r_q.ph_rd && r_q.ph_addr == adcc_pkg::ADDR_RL && !eng_done
      |=> !r_q.done)
      else $error("low result read did not clear done");

   AST_IRQ: assert property (
      @(posedge sys_clk) disable iff (reset)
      r_q.done && r_q.ien |-> irq)
      else $error("interrupt low with done and enable");

   AST_SINGLE: assert property (
      @(posedge sys_clk) disable iff (reset)
      eng_done && !r_q.cont && !wr_sc1 |=> !r_q.act && !converter_enable)
      else $error("single conversion did not stop");

   AST_CONT: assert property (
      @(posedge sys_clk) disable iff (reset)
      eng_done && r_q.cont && !wr_sc1 && r_q.ch != adcc_pkg::CH_OFF
      && !r_q.ph_wr ##1 !r_q.ph_wr |=> r_q.act)
      else $error("continuous mode did not repeat");

   AST_SAME_CYCLE: assert property (
      @(posedge sys_clk) disable iff (reset)
      eng_done && !wr_sc1 && upd
      |=> r_q.done && !r_q.act && r_q.result == $past(eng_result))
      else $error("completion effects split across cycles");

   AST_HW_TRIG: assert property (
      @(posedge sys_clk) disable iff (reset)
      hwt_rise && r_q.trig && !r_q.act && !r_q.ph_wr
      && r_q.ch != adcc_pkg::CH_OFF |=> r_q.act)
      else $error("hardware trigger ignored");

   COV_SW_DONE: cover property (@(posedge sys_clk) disable iff (reset)
      eng_done && !r_q.cmpen && !r_q.cont);
   COV_CONT: cover property (@(posedge sys_clk) disable iff (reset)
      r_q.restart && r_q.cont ##1 r_q.act);
   COV_HW: cover property (@(posedge sys_clk) disable iff (reset)
      hwt_rise && r_q.trig ##1 r_q.act);
   COV_MISS: cover property (@(posedge sys_clk) disable iff (reset)
      eng_done && r_q.cmpen && !upd);
endmodule : adcc_top

// *** tb/adcc_ana_model.sv ***
module adcc_ana_model (
   input wire logic [adcc_pkg::RES_W-1:0] dac_code,
   input wire logic [adcc_pkg::NUM_INPUTS-1:0] analog_input_sel,
   input wire logic ref_high_sel,
   input wire logic ref_low_sel,
   input wire logic input_isolate,
   output logic cmp_above
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [adcc_pkg::RES_W-1:0] lvl;
   always_comb begin
      lvl = '0;
      for (int i = 0; i < adcc_pkg::NUM_INPUTS; i++) begin
         if (analog_input_sel[i]) begin
            lvl = 10'(i * 32'h25 + 32'h5);
         end
      end
      if (ref_high_sel) begin
         lvl = 10'h3FF;
      end
      if (ref_low_sel) begin
         lvl = 10'h000;
      end
      if (input_isolate) begin
         lvl = 10'h000;
      end
      // Ideal comparator, so a clean SAR lands on lvl exactly
      cmp_above = (lvl >= dac_code);
   end
endmodule : adcc_ana_model

// *** tb/tb_top.sv ***
`define CHK(g, e) begin \
   n_checks++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); \
   end \
end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, reset, hsel, hwrite, hw_trigger_input, cmp_above;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, converter_enable, input_isolate, irq;
   logic [9:0] dac_code;
   logic [27:0] analog_input_sel;
   logic ref_high_sel, ref_low_sel;
   int failures, n_checks;

   adcc_top u_adcc_top (
      .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .hw_trigger_input(hw_trigger_input),
      .cmp_above(cmp_above), .dac_code(dac_code),
      .converter_enable(converter_enable), .input_isolate(input_isolate),
      .analog_input_sel(analog_input_sel), .ref_high_sel(ref_high_sel),
      .ref_low_sel(ref_low_sel), .irq(irq));

   adcc_ana_model u_adcc_ana_model (
      .dac_code(dac_code), .analog_input_sel(analog_input_sel),
      .ref_high_sel(ref_high_sel), .ref_low_sel(ref_low_sel),
      .input_isolate(input_isolate), .cmp_above(cmp_above));

   initial begin
      sys_clk = 1'h0;
      forever #10 sys_clk = ~sys_clk;
   end

   task summarize;
      if (failures == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   task abort_run;
      failures++;
      $display("MISMATCH t=%0t wait limit reached", $time);
      summarize();
   endtask : abort_run

   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc

   // Samples hreadyout as it stood before the edge
   task rdy;
      int k;
      k = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'h1) begin
         k++;
         if (k > 50) abort_run();
         @(posedge sys_clk);
      end
   endtask : rdy

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= adcc_pkg::HSIZE_WORD;
      rdy();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      rd = hrdata;
   endtask : bus

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask : wr

   task rdr(input logic [7:0] a);
      bus(1'h0, a, 32'h0);
   endtask : rdr

   task poll(input logic [7:0] a, input int b, input logic v);
      int k;
      k = 0;
      rdr(a);
      while (rd[b] !== v) begin
         k++;
         if (k > 100) abort_run();
         rdr(a);
      end
   endtask : poll

   task res(output logic [9:0] r);
      rdr(adcc_pkg::ADDR_RH);
      r[9:8] = rd[1:0];
      rdr(adcc_pkg::ADDR_RL);
      r[7:0] = rd[7:0];
   endtask : res

   function automatic logic [9:0] expv(input logic [4:0] c);
      if (c == adcc_pkg::CH_REFH) return 10'h3FF;
      if (c < adcc_pkg::CH_RSVD) return 10'(c * 32'h25 + 32'h5);
      return 10'h000;
   endfunction : expv

   task t_reset;
      rdr(adcc_pkg::ADDR_SC1);
      `CHK(rd, 32'h1F)
      rdr(adcc_pkg::ADDR_SC2);
      `CHK(rd, 32'h0)
      rdr(8'h20);
      `CHK(rd, 32'h0)
      `CHK(hresp, 1'h0)
      `CHK(input_isolate, 1'h1)
      `CHK(irq, 1'h0)
   endtask : t_reset

   task automatic t_channels;
      logic [4:0] cs [5] = '{5'h00, 5'h1B, 5'h1D, 5'h1E, 5'h1C};
      logic [27:0] es;
      logic [9:0] r;
      foreach (cs[i]) begin
         wr(adcc_pkg::ADDR_SC1, {27'h0, cs[i]});
         poll(adcc_pkg::ADDR_SC2, 7, 1'h0);
         es = (cs[i] < 5'h1C) ? 28'h1 << cs[i] : 28'h0;
         `CHK(analog_input_sel, es)
         `CHK(ref_high_sel, cs[i] == 5'h1D)
         `CHK(ref_low_sel, cs[i] == 5'h1E)
         `CHK(converter_enable, 1'h0)
         rdr(adcc_pkg::ADDR_SC1);
         `CHK(rd[7], 1'h1)
         res(r);
         `CHK(r, expv(cs[i]))
      end
   endtask : t_channels

   task t_irq;
      rdr(adcc_pkg::ADDR_IST);
      wr(adcc_pkg::ADDR_SC1, 32'h43);
      poll(adcc_pkg::ADDR_SC1, 7, 1'h1);
      `CHK(irq, 1'h1)
      rdr(adcc_pkg::ADDR_RL);
      rdr(adcc_pkg::ADDR_SC1);
      `CHK(rd[7], 1'h0)
      `CHK(irq, 1'h0)
      wr(adcc_pkg::ADDR_SC1, 32'h03);
      poll(adcc_pkg::ADDR_SC1, 7, 1'h1);
      `CHK(irq, 1'h0)
      wr(adcc_pkg::ADDR_IMSK, 32'h1);
      cyc(2);
      `CHK(irq, 1'h1)
      rdr(adcc_pkg::ADDR_IST);
      `CHK(rd[0], 1'h1)
      cyc(2);
      `CHK(irq, 1'h0)
      wr(adcc_pkg::ADDR_IMSK, 32'h0);
      wr(adcc_pkg::ADDR_SC1, 32'h1F);
      rdr(adcc_pkg::ADDR_SC1);
      `CHK(rd, 32'h1F)
   endtask : t_irq

   task t_abort;
      logic [9:0] r;
      wr(adcc_pkg::ADDR_SC1, 32'h05);
      cyc(30);
      wr(adcc_pkg::ADDR_SC1, 32'h06);
      poll(adcc_pkg::ADDR_SC2, 7, 1'h0);
      res(r);
      `CHK(r, expv(5'h06))
      rdr(adcc_pkg::ADDR_IST);
      `CHK(rd, 32'h5)
      cyc(200);
      rdr(adcc_pkg::ADDR_SC2);
      `CHK(rd[7], 1'h0)
   endtask : t_abort

   task t_cont;
      wr(adcc_pkg::ADDR_SC1, 32'h22);
      poll(adcc_pkg::ADDR_SC1, 7, 1'h1);
      rdr(adcc_pkg::ADDR_SC2);
      `CHK(rd[7], 1'h1)
      wr(adcc_pkg::ADDR_SC1, 32'h3F);
      rdr(adcc_pkg::ADDR_SC2);
      `CHK(rd[7], 1'h0)
      `CHK(converter_enable, 1'h0)
      `CHK(input_isolate, 1'h1)
      cyc(200);
      rdr(adcc_pkg::ADDR_SC1);
      `CHK(rd, 32'h3F)
   endtask : t_cont

   // Previous result is channel 2, so a missed compare must keep it
   task t_cmp;
      logic [9:0] r;
      wr(adcc_pkg::ADDR_CVH, 32'h0);
      wr(adcc_pkg::ADDR_CVL, 32'h50);
      wr(adcc_pkg::ADDR_SC2, 32'h20);
      rdr(adcc_pkg::ADDR_IST);
      wr(adcc_pkg::ADDR_SC1, 32'h04);
      poll(adcc_pkg::ADDR_SC2, 7, 1'h0);
      rdr(adcc_pkg::ADDR_IST);
      `CHK(rd, 32'h2)
      rdr(adcc_pkg::ADDR_SC1);
      `CHK(rd[7], 1'h0)
      res(r);
      `CHK(r, expv(5'h02))
      wr(adcc_pkg::ADDR_SC2, 32'h30);
      wr(adcc_pkg::ADDR_SC1, 32'h04);
      poll(adcc_pkg::ADDR_SC2, 7, 1'h0);
      rdr(adcc_pkg::ADDR_SC1);
      `CHK(rd[7], 1'h1)
      res(r);
      `CHK(r, expv(5'h04))
      wr(adcc_pkg::ADDR_SC2, 32'h0);
   endtask : t_cmp

   task t_hw;
      logic [9:0] r;
      wr(adcc_pkg::ADDR_SC2, 32'h40);
      wr(adcc_pkg::ADDR_SC1, 32'h07);
      rdr(adcc_pkg::ADDR_SC2);
      `CHK(rd, 32'h40)
      hw_trigger_input <= 1'h1;
      cyc(3);
      hw_trigger_input <= 1'h0;
      rdr(adcc_pkg::ADDR_SC2);
      `CHK(rd[7], 1'h1)
      `CHK(converter_enable, 1'h1)
      `CHK(input_isolate, 1'h0)
      poll(adcc_pkg::ADDR_SC2, 7, 1'h0);
      res(r);
      `CHK(r, expv(5'h07))
      cyc(200);
      rdr(adcc_pkg::ADDR_SC2);
      `CHK(rd, 32'h40)
      wr(adcc_pkg::ADDR_SC2, 32'h0);
   endtask : t_hw

   initial begin
      reset = 1'h1;
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h0;
      hwdata = 32'h0;
      hw_trigger_input = 1'h0;
      failures = 0;
      n_checks = 0;
      repeat (6) @(posedge sys_clk);
      reset <= 1'h0;
      @(posedge sys_clk);
      t_reset();
      t_channels();
      t_irq();
      t_abort();
      t_cont();
      t_cmp();
      t_hw();
      summarize();
   end
endmodule : tb_top
